// ---- rtl/lag_map.svh ----
`ifndef LAG_MAP_SVH
`define LAG_MAP_SVH
// Functional notes
// (RQ1) Every frame of a flow uses one member.
// (RQ2) Hash uses MACs, IPv4 addresses, L4 ports.
// (RQ3) Global hash enables; reset: all but DMAC.
// (RQ4) One group per port; normal joins none.
// (RQ5) Reset leaves every port ungrouped.
// (RQ6) Ten members per group, five groups.
// (RQ7) Extra protocol ports stand by, then take over.
// (RQ8) Protocol group needs two ports, same partner.
// (RQ9) Key 1 to 65535, automatic or user set.
// (RQ10) Automatic key: 10M=1, 100M=2, 1G=3.
// (RQ11) Only equal keys aggregate together.
// (RQ12) Active sends alone; passive answers partner.
// (RQ13) Fast sends each second, slow every 30.
// (RQ14) Lower priority value wins active place.
// (RQ15) Protocol runs on full-duplex ports only.
// (RQ16) Group members share one link speed.
// (RQ17) Members are never mirror source or target.
// (RQ18) Peer configures its ends before cabling.
// (RQ19) Hash modulo active members picks egress.
`define LAG_NPORT 10
`define LAG_NGRP 3'd5
`define LAG_MAX_ACT 8
`define LAG_A_HASH 8'h00
`define LAG_A_ACT 8'h04
`define LAG_A_SBY 8'h08
`define LAG_A_MIR 8'h0c
`define LAG_B_PCFG 2'h1
`define LAG_B_PRIO 2'h2
`define LAG_B_KEY 2'h3
`define LAG_F_LACP 3
`define LAG_F_KUSR 4
`define LAG_F_ACT 5
`define LAG_F_FAST 6
`define LAG_F_KEY 31:16
`define LAG_H_SMAC 0
`define LAG_H_DMAC 1
`define LAG_H_IP 2
`define LAG_H_L4 3
`define LAG_HASH_RST 4'hd
`define LAG_PCFG_RST 32'h0000_0060
`define LAG_PRIO_RST 16'h8000
`define LAG_KEY_10M 16'h0001
`define LAG_KEY_100M 16'h0002
`define LAG_KEY_1G 16'h0003
`define LAG_CLK_MHZ 50
`define LAG_TICK_MS 1000
`define LAG_FAST_S 1
`define LAG_SLOW_S 30
`endif

// ---- rtl/lag_pkg.sv ----
package lag_pkg;
    typedef struct packed {
        logic link;
        logic fdx;
        logic [1:0] speed;
    } lag_pstat_t;
    typedef struct packed {
        logic [47:0] smac;
        logic [47:0] dmac;
        logic [31:0] sip;
        logic [31:0] dip;
        logic [15:0] sport;
        logic [15:0] dport;
        logic ipv4;
        logic l4;
        logic [2:0] grp;
    } lag_hdr_t;
    typedef struct packed {
        logic hit;
        logic [3:0] port;
        logic [2:0] grp;
    } lag_res_t;
endpackage

// ---- rtl/lag_port_select.sv ----
`timescale 1ns/1ps
`include "lag_map.svh"
module lag_port_select #(
    parameter int unsigned TICK_CYCLES = `LAG_TICK_MS * 1000 * `LAG_CLK_MHZ
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Port state and protocol events
    input wire lag_pkg::lag_pstat_t [`LAG_NPORT-1:0] phy_stat,
    input wire logic [`LAG_NPORT-1:0] partner_rx,
    input wire logic [47:0] partner_sys [`LAG_NPORT],
    output logic [`LAG_NPORT-1:0] lacp_tx,
    output logic [`LAG_NPORT-1:0] mirror_ok,
    // Frame headers in
    input wire logic hdr_valid,
    output logic hdr_ready,
    input wire lag_pkg::lag_hdr_t hdr,
    // Egress choice out
    output logic res_valid,
    input wire logic res_ready,
    output lag_pkg::lag_res_t res
);
    localparam int NP = `LAG_NPORT;
    localparam logic [3:0] NPW = 4'(NP);

    function automatic logic [7:0] fold(input logic [47:0] v);
        fold = v[7:0] ^ v[15:8] ^ v[23:16] ^ v[31:24] ^ v[39:32] ^ v[47:40];
    endfunction

    function automatic logic [3:0] popc(input logic [NP-1:0] m);
        popc = 4'h0;
        for (int i = 0; i < NP; i++) begin
            popc = popc + {3'h0, m[i]};
        end
    endfunction

    function automatic logic [3:0] nth(input logic [NP-1:0] m,
                                       input logic [3:0] k);
        logic [3:0] c;
        c = 4'h0;
        nth = 4'h0;
        for (int i = 0; i < NP; i++) begin
            if (m[i]) begin
                if (c == k) begin
                    nth = 4'(i);
                end
                c = c + 4'h1;
            end
        end
    endfunction

    function automatic logic is_norm(input logic [2:0] g);
        is_norm = g == 3'h0 || g > `LAG_NGRP;
    endfunction

    // Port state pins cross into the clock domain here.
    lag_pkg::lag_pstat_t [NP-1:0] stat_m_q;
    lag_pkg::lag_pstat_t [NP-1:0] stat_q;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stat_m_q <= '0;
            stat_q <= '0;
        end else begin
            stat_m_q <= phy_stat;
            stat_q <= stat_m_q;
        end
    end

    // Configuration registers.
    logic [3:0] hash_en_q;
    logic [31:0] pcfg_q [NP];
    logic [15:0] prio_q [NP];
    logic [3:0] widx;
    logic widx_ok;
    assign widx = reg_addr[5:2];
    assign widx_ok = widx < NPW;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hash_en_q <= `LAG_HASH_RST; // [RQ3]
            for (int p = 0; p < NP; p++) begin
                pcfg_q[p] <= `LAG_PCFG_RST; // [RQ5]
                prio_q[p] <= `LAG_PRIO_RST; // [RQ14]
            end
        end else if (reg_wr) begin
            if (reg_addr == `LAG_A_HASH) begin
                hash_en_q <= reg_wdata[3:0]; // [RQ3]
            end
            if (reg_addr[7:6] == `LAG_B_PCFG && widx_ok) begin
                pcfg_q[widx] <= reg_wdata;
            end
            if (reg_addr[7:6] == `LAG_B_PRIO && widx_ok) begin
                prio_q[widx] <= reg_wdata[15:0];
            end
        end
    end

    // Per-port derived state.
    logic [2:0] grp [NP];
    logic [15:0] key [NP];
    logic [NP-1:0] up;
    logic [NP-1:0] lacp;
    logic [NP-1:0] norm;
    always_comb begin
        for (int p = 0; p < NP; p++) begin
            grp[p] = pcfg_q[p][2:0];
            norm[p] = is_norm(grp[p]); // [RQ4] [RQ6]
            up[p] = stat_q[p].link && stat_q[p].fdx;
            lacp[p] = pcfg_q[p][`LAG_F_LACP] && up[p]; // [RQ15]
            if (pcfg_q[p][`LAG_F_KUSR]) begin
                // A user key of zero is out of range and reads as one.
                key[p] = pcfg_q[p][`LAG_F_KEY] == 16'h0 ? 16'h0001
                         : pcfg_q[p][`LAG_F_KEY]; // [RQ9]
            end else begin
                unique case (stat_q[p].speed)
                    2'h0: key[p] = `LAG_KEY_10M; // [RQ10]
                    2'h1: key[p] = `LAG_KEY_100M; // [RQ10]
                    default: key[p] = `LAG_KEY_1G; // [RQ10]
                endcase
            end
        end
    end

    // Partner identity as last heard on each port.
    logic [NP-1:0] seen_q;
    logic [47:0] partner_q [NP];
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            seen_q <= '0;
            for (int p = 0; p < NP; p++) begin
                partner_q[p] <= 48'h0;
            end
        end else begin
            for (int p = 0; p < NP; p++) begin
                if (!lacp[p]) begin
                    seen_q[p] <= 1'b0;
                end else if (partner_rx[p]) begin
                    seen_q[p] <= 1'b1;
                    partner_q[p] <= partner_sys[p];
                end
            end
        end
    end

    // A port may join when it matches the group's first live port.
    logic [NP-1:0] elig;
    always_comb begin
        elig = '0;
        for (int p = 0; p < NP; p++) begin
            int lead;
            int peers;
            lead = p;
            peers = 0;
            for (int q = NP - 1; q >= 0; q--) begin
                if (grp[q] == grp[p] && up[q]) begin
                    lead = q;
                end
                if (grp[q] == grp[p] && lacp[q] && seen_q[q] &&
                    partner_q[q] == partner_q[p]) begin
                    peers++; // [RQ8]
                end
            end
            elig[p] = !norm[p] && up[p] &&
                      key[p] == key[lead] && // [RQ11]
                      stat_q[p].speed == stat_q[lead].speed && // [RQ16]
                      (!pcfg_q[p][`LAG_F_LACP] ||
                       (seen_q[p] && peers >= 2)); // [RQ8]
        end
    end

    // Protocol ports rank by priority; the overflow stands by.
    logic [NP-1:0] act_d;
    logic [NP-1:0] sby_d;
    always_comb begin
        act_d = '0;
        sby_d = '0;
        for (int p = 0; p < NP; p++) begin
            int rank;
            rank = 0;
            for (int q = 0; q < NP; q++) begin
                if (elig[q] && lacp[q] && grp[q] == grp[p] &&
                    (prio_q[q] < prio_q[p] ||
                     (prio_q[q] == prio_q[p] && q < p))) begin
                    rank++; // [RQ14]
                end
            end
            act_d[p] = elig[p] && (!lacp[p] || rank < `LAG_MAX_ACT); // [RQ7]
            sby_d[p] = elig[p] && !act_d[p]; // [RQ7]
        end
    end

    logic [NP-1:0] active_q;
    logic [NP-1:0] standby_q;
    logic [NP-1:0] mirror_q;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            active_q <= '0;
            standby_q <= '0;
            mirror_q <= '1;
        end else begin
            active_q <= act_d;
            standby_q <= sby_d;
            mirror_q <= norm; // [RQ17]
        end
    end
    assign mirror_ok = mirror_q;

    // Hash of the enabled fields, reduced over the live members.
    logic [7:0] hval;
    logic [NP-1:0] mem;
    logic [3:0] nmem;
    logic [3:0] slot;
    lag_pkg::lag_res_t sel;
    always_comb begin
        hval = 8'h00;
        if (hash_en_q[`LAG_H_SMAC]) begin
            hval = hval ^ fold(hdr.smac); // [RQ2]
        end
        if (hash_en_q[`LAG_H_DMAC]) begin
            hval = hval ^ fold(hdr.dmac); // [RQ2]
        end
        if (hash_en_q[`LAG_H_IP] && hdr.ipv4) begin
            hval = hval ^ fold({hdr.sip, hdr.dip[31:16]}) ^
                   fold({32'h0, hdr.dip[15:0]}); // [RQ2]
        end
        if (hash_en_q[`LAG_H_L4] && hdr.ipv4 && hdr.l4) begin
            hval = hval ^ fold({16'h0, hdr.sport, hdr.dport}); // [RQ2]
        end
        for (int p = 0; p < NP; p++) begin
            mem[p] = active_q[p] && grp[p] == hdr.grp; // [RQ4]
        end
        nmem = popc(mem);
        slot = nmem == 4'h0 ? 4'h0 : 4'(hval % {4'h0, nmem}); // [RQ19]
        sel.hit = nmem != 4'h0 && !is_norm(hdr.grp);
        sel.port = nth(mem, slot); // [RQ1]
        sel.grp = hdr.grp;
    end

    // Two-entry result buffer; a stalled receiver loses nothing.
    lag_pkg::lag_res_t buf_q [2];
    logic wp_q;
    logic rp_q;
    logic [1:0] cnt_q;
    logic enq;
    logic deq;
    assign hdr_ready = cnt_q != 2'h2;
    assign res_valid = cnt_q != 2'h0;
    assign res = buf_q[rp_q];
    assign enq = hdr_valid && hdr_ready;
    assign deq = res_valid && res_ready;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            buf_q[0] <= '0;
            buf_q[1] <= '0;
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (enq) begin
                buf_q[wp_q] <= sel;
                wp_q <= ~wp_q;
            end
            if (deq) begin
                rp_q <= ~rp_q;
            end
            cnt_q <= 2'(cnt_q + {1'b0, enq} - {1'b0, deq});
        end
    end

    // One-second enable for the protocol transmit timers.
    logic [25:0] div_q;
    logic tick;
    assign tick = div_q == 26'(TICK_CYCLES - 1);
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            div_q <= 26'h0;
        end else begin
            div_q <= tick ? 26'h0 : div_q + 26'h1;
        end
    end

    logic [4:0] sec_q [NP];
    logic [NP-1:0] heard_q;
    logic [NP-1:0] tx_q;
    logic [NP-1:0] run;
    logic [NP-1:0] role_act;
    always_comb begin
        for (int p = 0; p < NP; p++) begin
            role_act[p] = pcfg_q[p][`LAG_F_ACT];
            run[p] = lacp[p] && (role_act[p] || heard_q[p]); // [RQ12]
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            heard_q <= '0;
            tx_q <= '0;
            for (int p = 0; p < NP; p++) begin
                sec_q[p] <= 5'h0;
            end
        end else begin
            for (int p = 0; p < NP; p++) begin
                tx_q[p] <= 1'b0;
                if (!lacp[p]) begin
                    heard_q[p] <= 1'b0;
                end else if (partner_rx[p]) begin
                    heard_q[p] <= 1'b1; // [RQ12]
                end
                if (!run[p]) begin
                    sec_q[p] <= 5'h0;
                end else if (tick) begin
                    if (sec_q[p] >= (pcfg_q[p][`LAG_F_FAST] ?
                        5'(`LAG_FAST_S - 1) : 5'(`LAG_SLOW_S - 1))) begin
                        sec_q[p] <= 5'h0;
                        tx_q[p] <= 1'b1; // [RQ13]
                    end else begin
                        sec_q[p] <= sec_q[p] + 5'h1;
                    end
                end
            end
        end
    end
    assign lacp_tx = tx_q;

    // Read data stands only in the cycle after the strobe.
    logic [31:0] rdata_q;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 32'h0;
        end else begin
            rdata_q <= 32'h0;
            if (reg_rd) begin
                if (reg_addr == `LAG_A_HASH) begin
                    rdata_q <= {28'h0, hash_en_q};
                end
                if (reg_addr == `LAG_A_ACT) begin
                    rdata_q <= {22'h0, active_q};
                end
                if (reg_addr == `LAG_A_SBY) begin
                    rdata_q <= {22'h0, standby_q};
                end
                if (reg_addr == `LAG_A_MIR) begin
                    rdata_q <= {22'h0, mirror_q};
                end
                if (reg_addr[7:6] == `LAG_B_PCFG && widx_ok) begin
                    rdata_q <= pcfg_q[widx];
                end
                if (reg_addr[7:6] == `LAG_B_PRIO && widx_ok) begin
                    rdata_q <= {16'h0, prio_q[widx]};
                end
                if (reg_addr[7:6] == `LAG_B_KEY && widx_ok) begin
                    rdata_q <= {16'h0, key[widx]};
                end
            end
        end
    end
    assign reg_rdata = rdata_q;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence s_quiet_passive;
        (~role_act & ~heard_q & ~partner_rx) != '0;
    endsequence

    sequence s_same_flow;
        enq && $past(enq) && hdr == $past(hdr) && $stable(active_q) &&
        $stable(hash_en_q) && $stable(mem);
    endsequence

    AST_SAME_FLOW: assert property (s_same_flow |-> sel == $past(sel)) // [RQ1]
        else $error("One flow moved to another member.");
    AST_HIT_MEMBER: assert property (enq && sel.hit |-> // [RQ19]
        mem[sel.port] && active_q[sel.port])
        else $error("Egress port is not a live member.");
    AST_NO_HASH: assert property (enq && sel.hit && hash_en_q == 4'h0 |-> // [RQ19]
        sel.port == nth(mem, 4'h0))
        else $error("Empty hash did not pick the first member.");
    AST_NORMAL: assert property (1 |=> (active_q & $past(norm)) == '0) // [RQ4]
        else $error("Ungrouped port became a member.");
    AST_MIRROR: assert property (1 |=> (mirror_ok & active_q) == '0) // [RQ17]
        else $error("Member port offered for mirroring.");
    AST_STANDBY: assert property ( // [RQ7]
        (standby_q & (active_q | ~$past(lacp))) == '0)
        else $error("Standby port is active or not negotiating.");
    AST_TX_TICK: assert property (lacp_tx != '0 |-> $past(tick)) // [RQ13]
        else $error("Protocol send off the one-second enable.");
    AST_PASSIVE: assert property (s_quiet_passive |=> // [RQ12]
        (lacp_tx & ~heard_q &
         $past(~role_act & ~heard_q & ~partner_rx)) == '0)
        else $error("Passive port spoke unprompted.");
    AST_FDX: assert property (lacp_tx[0] |-> $past(stat_q[0].fdx)) // [RQ15]
        else $error("Protocol sent on a half-duplex port.");
    AST_GROUP_SIZE: assert property (popc(active_q & lacp) <= 4'd10) // [RQ6]
        else $error("Group grew past ten members.");
    AST_BUF_HOLD: assert property (res_valid && !res_ready |=>
        res_valid && $stable(res))
        else $error("Stalled result changed or vanished.");
endmodule

// ---- verification/lag_peer_model.sv ----
`timescale 1ns/1ps
`include "lag_map.svh"
module lag_peer_model #(
    parameter int PERIOD = 50,
    // Arbitrary system identity for the peer.
    parameter logic [47:0] SYS_ID = 48'h0200_0000_0a01
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Peer configuration and device traffic
    input wire logic [`LAG_NPORT-1:0] peer_on,
    input wire logic [`LAG_NPORT-1:0] lacp_tx,
    // Protocol packets toward the device
    output logic [`LAG_NPORT-1:0] partner_rx,
    output logic [47:0] partner_sys [`LAG_NPORT]
);
    int tick_q;
    logic [`LAG_NPORT-1:0] rx_d;

    // Only ports the peer has configured as members speak or answer.
    assign rx_d = peer_on & ({`LAG_NPORT{tick_q == PERIOD - 1}} | lacp_tx);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tick_q <= 0;
        end else begin
            tick_q <= (tick_q == PERIOD - 1) ? 0 : tick_q + 1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            partner_rx <= '0;
        end else begin
            partner_rx <= rx_d;
        end
    end

    // Outside a packet the identity lines show the inverse of SYS_ID.
    always_ff @(posedge sys_clk or posedge rst) begin
        for (int p = 0; p < `LAG_NPORT; p++) begin
            if (rst) begin
                partner_sys[p] <= ~SYS_ID;
            end else begin
                partner_sys[p] <= rx_d[p] ? SYS_ID : ~SYS_ID;
            end
        end
    end
endmodule

// ---- verification/link_aggregation_port_select_tb.sv ----
`timescale 1ns/1ps
`include "lag_map.svh"
module link_aggregation_port_select_tb;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    // Ports 0-3 and 6-8 run 1G full, 4 100M, 5 10M, 9 1G half duplex.
    lag_pkg::lag_pstat_t [`LAG_NPORT-1:0] phy_stat = 40'hae_eecd_eeee;
    logic [`LAG_NPORT-1:0] partner_rx, lacp_tx, mirror_ok;
    logic [`LAG_NPORT-1:0] peer_on = '0;
    logic [47:0] partner_sys [`LAG_NPORT];
    logic hdr_valid = 1'b0;
    logic hdr_ready, res_valid;
    logic res_ready = 1'b1;
    lag_pkg::lag_hdr_t hdr = '0;
    lag_pkg::lag_res_t res, r0, r1, r2;
    logic [3:0] pr [6];
    int err_count = 0;
    int n_compared = 0;
    int cnt [`LAG_NPORT] = '{default: 0};
    int g;
    logic [39:0] rows [14] = '{40'h00_0000_000d, 40'h04_0000_0000,
        40'h08_0000_0000, 40'h0c_0000_03ff, 40'h10_0000_0000,
        40'h40_0000_0060, 40'h64_0000_0060, 40'h80_0000_8000,
        40'ha4_0000_8000, 40'hc0_0000_0003, 40'hd0_0000_0002,
        40'hd4_0000_0001, 40'he4_0000_0003, 40'he8_0000_0000};

    lag_port_select #(.TICK_CYCLES(20)) lag_port_select_inst (
        .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .phy_stat(phy_stat), .partner_rx(partner_rx),
        .partner_sys(partner_sys), .lacp_tx(lacp_tx), .mirror_ok(mirror_ok),
        .hdr_valid(hdr_valid), .hdr_ready(hdr_ready), .hdr(hdr),
        .res_valid(res_valid), .res_ready(res_ready), .res(res)
    );

    lag_peer_model lag_peer_model_inst (
        .sys_clk(sys_clk), .rst(rst), .peer_on(peer_on), .lacp_tx(lacp_tx),
        .partner_rx(partner_rx), .partner_sys(partner_sys)
    );

    always #10 sys_clk = ~sys_clk;

    always @(negedge sys_clk) begin
        for (int p = 0; p < `LAG_NPORT; p++) begin
            if (lacp_tx[p] === 1'b1) begin
                cnt[p] <= cnt[p] + 1;
            end
        end
    end

    task automatic complete_run();
        if (err_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic fail_wait();
        err_count++;
        complete_run();
    endtask

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    function automatic lag_pkg::lag_hdr_t mk(input logic [47:0] sm,
                                             input logic [2:0] gp);
        mk = '{smac: sm, dmac: 48'h0a0b_0c0d_0e0f, sip: 32'h0a00_0001,
               dip: 32'h0a00_0002, sport: 16'h1234, dport: 16'h0050,
               ipv4: 1'b1, l4: 1'b1, grp: gp};
    endfunction

    task automatic send(input lag_pkg::lag_hdr_t h);
        @(posedge sys_clk);
        hdr_valid <= 1'b1;
        hdr <= h;
        for (int i = 0; i < 100; i++) begin
            @(negedge sys_clk);
            if (hdr_ready === 1'b1) begin
                @(posedge sys_clk);
                hdr_valid <= 1'b0;
                return;
            end
        end
        fail_wait();
    endtask

    task automatic recv(output lag_pkg::lag_res_t r);
        for (int i = 0; i < 100; i++) begin
            @(negedge sys_clk);
            if (res_valid === 1'b1) begin
                r = res;
                @(posedge sys_clk);
                return;
            end
        end
        fail_wait();
    endtask

    // Counts clock edges between two transmit pulses of one port.
    task automatic gap(input int p, input int exp);
        int c0;
        int t;
        c0 = cnt[p];
        for (t = 0; t < 1500 && cnt[p] < c0 + 1; t++) @(posedge sys_clk);
        for (t = 0; t < 1500 && cnt[p] < c0 + 2; t++) @(posedge sys_clk);
        chk(t, exp);
    endtask

    initial begin
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(mirror_ok, 10'h3ff);
        chk({lacp_tx, hdr_ready, res_valid, reg_rdata},
            44'h2_0000_0000);
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        wr(8'h10, 32'hffff_ffff);
        for (int i = 0; i < 14; i++) begin
            rd(rows[i][39:32], rows[i][31:0]);
        end
        wr(8'h4c, 32'h0000_0010);
        rd(8'hcc, 32'h0000_0001);
        wr(8'h4c, 32'hbeef_0010);
        rd(8'hcc, 32'h0000_beef);
        // Static group 1: ports 0-2 at 1G, port 4 at 100M with another key.
        foreach (rows[i]) if (i < 3 || i == 4) wr(8'h40 + 8'(4 * i), 32'h61);
        repeat (4) @(posedge sys_clk);
        rd(8'h04, 32'h0000_0007);
        rd(8'h0c, 32'h0000_03e8);
        chk(mirror_ok, 10'h3e8);
        wr(8'h00, 32'h0);
        for (int i = 0; i < 3; i++) begin
            send(mk(48'(i), 3'h1));
            recv(r0);
            chk(r0, 8'h81);
        end
        wr(8'h00, 32'h1);
        for (int i = 0; i < 6; i++) begin
            send(mk(48'(i), 3'h1));
            recv(r0);
            pr[i] = r0.port;
            chk({r0.hit, r0.grp, r0.port < 4'h3}, 5'h13);
        end
        chk(pr[0] != pr[1] || pr[1] != pr[2], 1);
        send(mk(48'h4, 3'h1));
        recv(r0);
        chk(r0.port, pr[4]);
        wr(8'h00, 32'h2);
        send(mk(48'h0, 3'h1));
        recv(r1);
        send(mk(48'h1, 3'h1));
        recv(r2);
        chk(r2, r1);
        send(mk(48'h1, 3'h0));
        recv(r0);
        chk(r0, 8'h00);
        @(posedge sys_clk);
        res_ready <= 1'b0;
        send(mk(48'h1, 3'h1));
        send(mk(48'h2, 3'h0));
        @(negedge sys_clk);
        chk(hdr_ready, 1'b0);
        fork
            send(mk(48'h3, 3'h1));
            begin
                repeat (3) @(posedge sys_clk);
                res_ready <= 1'b1;
                recv(r0);
                recv(r1);
                recv(r2);
            end
        join
        chk({r0.hit, r0.grp, r1.hit, r1.grp, r2.hit, r2.grp}, 12'h909);
        // Two headers of one flow taken on back-to-back edges.
        res_ready <= 1'b0;
        hdr_valid <= 1'b1;
        hdr <= mk(48'h5, 3'h1);
        repeat (2) @(posedge sys_clk);
        hdr_valid <= 1'b0;
        res_ready <= 1'b1;
        recv(r1);
        recv(r2);
        chk(r2, r1);
        // Protocol group 2: 6 active fast, 7 active slow, 8 passive, 9 half.
        peer_on <= 10'h0c0;
        wr(8'h58, 32'h6a);
        wr(8'h5c, 32'h2a);
        wr(8'h60, 32'h4a);
        wr(8'h64, 32'h6a);
        gap(6, 20);
        gap(7, 600);
        chk({cnt[8], cnt[9]}, 64'h0);
        rd(8'h04, 32'h0000_00c7);
        chk(mirror_ok, 10'h028);
        peer_on <= 10'h1c0;
        for (g = 0; g < 300 && cnt[8] == 0; g++) @(posedge sys_clk);
        chk(cnt[8] != 0, 1);
        rd(8'h04, 32'h0000_01c7);
        @(posedge sys_clk);
        phy_stat[6] <= 4'h0;
        repeat (6) @(posedge sys_clk);
        rd(8'h04, 32'h0000_0187);
        // Ten live protocol ports in one group: port 9 wins on priority.
        @(posedge sys_clk);
        phy_stat <= 40'hee_eeee_eeee;
        peer_on <= '1;
        wr(8'ha4, 32'h0000_0001);
        for (int i = 0; i < 10; i++) wr(8'h40 + 8'(4 * i), 32'h6a);
        repeat (100) @(posedge sys_clk);
        rd(8'h04, 32'h0000_027f);
        rd(8'h08, 32'h0000_0180);
        @(posedge sys_clk);
        phy_stat[0] <= 4'h0;
        repeat (6) @(posedge sys_clk);
        rd(8'h04, 32'h0000_02fe);
        rd(8'h08, 32'h0000_0100);
        complete_run();
    end
endmodule
